/* rtl/srocfg_bank.sv */
`default_nettype none
module srocfg_bank #(
  parameter int NUM_OUTPUTS = srocfg_pkg::NUM_OUT
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire srocfg_pkg::srocfg_bus_s bus_in,
  output logic [7:0] rdata_out,
  output logic bias_type_out,
  output wire srocfg_pkg::srocfg_drive_s [NUM_OUTPUTS-1:0] drive_out,
  output wire logic [NUM_OUTPUTS-1:0] clock_gate_out
);
  import srocfg_pkg::*;

  // Block overview
  // Software reaches eighteen byte registers over a plain strobe port.
  // A write lands at the edge that samples the write strobe.
  // A read is registered, so its data stand from the next cycle on.
  // Nothing here ever stalls the master; strobes may run back to back.
  // A read right after a write to the same byte sees the new value.
  //
  // Output order inside every per-output array
  // Index 0 is A0, then A1, A2, B0, B1, C0, C1, and index 7 is D.
  // The same order is used by the shared enable byte, reversed in bits.
  //
  // Phase byte of one output
  // Bit 7 is unused and reads as zero.
  // Bits 6 and 5 hold the two low bits of the fine delay code.
  // Bit 4 picks the source: low for the channel clock, high for sysref.
  // Bits 3 down to 1 hold the coarse delay code.
  // Bit 0 holds the top bit of the fine delay code.
  // The fine code is therefore split, and must be joined on every access.
  //
  // State byte of one output
  // Bit 7 powers the output down when high.
  // Bit 6 is unused and reads as zero.
  // Bit 5 asks for the LVDS cross-point bias.
  // Bit 4 selects the format: low for LVDS, high for LVPECL.
  // Bits 3 and 2 hold the amplitude code.
  // Bits 1 and 0 are unused and read as zero.
  //
  // Shared enable byte
  // One enable per output, A0 in bit 7 down to D in bit 0.
  // A cleared enable parks the output at logic low.
  //
  // Global bias type byte
  // Only bit 7 is stored here; other bits are dropped and read as zero.
  // A per-output bias request does nothing while this bit is clear.
  //
  // Unmapped addresses
  // Writes to them change nothing; reads from them return zero.
  //
  // Drive decode
  // The decode per output is purely combinational from the registers.
  // Power-down forces the toggle, format and amplitude controls to
  // their quiet values, so a powered-down output never looks active.
  // The bias decode is not gated by format: keeping bias off LVPECL
  // outputs is the configuring software's duty.
  // The coarse code is handed on as a code; the analog delay line
  // turns it into whole steps of 254 ps.
  //
  // Reset
  // The reset is synchronous and active high.
  // After it every output selects sysref, all delays are zero, bias is
  // off, amplitude is the smallest, format is LVDS, and all outputs are
  // powered up but disabled, so they sit low until software enables
  // them. The read data register also clears.
  //
  // Hazards
  // Write and read strobes never come together; if they did, the read
  // would return the old value because the write lands at the same edge.
  // The read data hold until the next read strobe; a user must not
  // depend on that hold, it is only a side effect of the enable.

  // Phase and state register addresses per output, index 0 is A0
  localparam logic [7:0] PHASE_ADDR [8] = '{ADDR_PHASE_A0, ADDR_PHASE_A1, ADDR_PHASE_A2,
    ADDR_PHASE_B0, ADDR_PHASE_B1, ADDR_PHASE_C0, ADDR_PHASE_C1, ADDR_PHASE_D};
  localparam logic [7:0] STATE_ADDR [8] = '{ADDR_STATE_A0, ADDR_STATE_A1, ADDR_STATE_A2,
    ADDR_STATE_B0, ADDR_STATE_B1, ADDR_STATE_C0, ADDR_STATE_C1, ADDR_STATE_D};

  // Stored fields of every output
  srocfg_fields_s fields [NUM_OUTPUTS];
  // Global bias type bit
  logic bias_type;
  // Read mux result per output, ORed together
  logic [7:0] phase_rd [NUM_OUTPUTS];
  logic [7:0] state_rd [NUM_OUTPUTS];
  logic [NUM_OUTPUTS-1:0] phase_hit;
  logic [NUM_OUTPUTS-1:0] state_hit;
  // Combined read value
  logic [7:0] next_rdata;

  // Global bias type register
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      bias_type <= RST_BIAS_TYPE;
    end else if (bus_in.wr && bus_in.addr == ADDR_BIAS_TYPE) begin
      bias_type <= bus_in.wdata[BIAS_TYPE_BIT];
    end
  end
  assign bias_type_out = bias_type;

  // One field set per output
  for (genvar i = 0; i < NUM_OUTPUTS; i++) begin : g_out
    assign phase_hit[i] = bus_in.addr == PHASE_ADDR[i];
    assign state_hit[i] = bus_in.addr == STATE_ADDR[i];

    // Field storage for output i
    always_ff @(posedge clk_in) begin
      if (srst_in) begin
        // Defaults after reset
        fields[i].src_sysref <= RST_SRC;
        fields[i].coarse <= RST_COARSE;
        fields[i].fine <= RST_FINE;
        fields[i].bias <= RST_BIAS;
        fields[i].amp <= RST_AMP;
        fields[i].pd <= RST_PD;
        fields[i].style <= RST_STYLE;
        fields[i].en <= RST_EN;
      end else if (bus_in.wr) begin
        // Phase register: fine delay split across bit 0 and bits 6:5
        if (phase_hit[i]) begin
          fields[i].src_sysref <= bus_in.wdata[SRC_POS];
          fields[i].coarse <= bus_in.wdata[COARSE_POS +: 3];
          fields[i].fine <= {bus_in.wdata[FINE_HI_POS], bus_in.wdata[FINE_LO_POS +: 2]};
        end
        // State register
        if (state_hit[i]) begin
          fields[i].pd <= bus_in.wdata[PD_POS];
          fields[i].bias <= bus_in.wdata[BIAS_POS];
          fields[i].style <= bus_in.wdata[STYLE_POS];
          fields[i].amp <= bus_in.wdata[AMP_POS +: 2];
        end
        // Shared enable register, A0 in bit 7 down to D in bit 0
        if (bus_in.addr == ADDR_ENABLE) begin
          fields[i].en <= bus_in.wdata[7-i];
        end
      end
    end

    // Read-back images, reserved bits zero
    assign phase_rd[i] = phase_hit[i] ? {1'b0, fields[i].fine[1:0], fields[i].src_sysref,
      fields[i].coarse, fields[i].fine[2]} : 8'h00;
    assign state_rd[i] = state_hit[i] ? {fields[i].pd, 1'b0, fields[i].bias, fields[i].style,
      fields[i].amp, 2'h0} : 8'h00;

    // Effective drive decode
    srocfg_channel u_chan (
      .fields_in(fields[i]),
      .bias_type_in(bias_type),
      .drive_out(drive_out[i])
    );

    // Output clock gate: powered and enabled, else held low
    assign clock_gate_out[i] = drive_out[i].toggling;
  end

  // Read data combine
  always_comb begin
    next_rdata = 8'h00;
    for (int i = 0; i < NUM_OUTPUTS; i++) begin
      next_rdata = next_rdata | phase_rd[i] | state_rd[i];
      if (bus_in.addr == ADDR_ENABLE) begin
        next_rdata[7-i] = fields[i].en;
      end
    end
    if (bus_in.addr == ADDR_BIAS_TYPE) begin
      next_rdata[BIAS_TYPE_BIT] = bias_type;
    end
  end

  // Read data register, valid the cycle after the read strobe
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_out <= 8'h00;
    end else if (bus_in.rd) begin
      rdata_out <= next_rdata;
    end
  end
endmodule
`default_nettype wire

/* rtl/srocfg_pkg.sv */
`default_nettype none
package srocfg_pkg;
  // Number of sysref capable outputs
  localparam int NUM_OUT = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // Register map A: source select and delays
  localparam logic [7:0] ADDR_PHASE_A0 = 8'h28;
  localparam logic [7:0] ADDR_PHASE_A1 = 8'h29;
  localparam logic [7:0] ADDR_PHASE_A2 = 8'h2A;
  localparam logic [7:0] ADDR_PHASE_B0 = 8'h38;
  localparam logic [7:0] ADDR_PHASE_B1 = 8'h39;
  localparam logic [7:0] ADDR_PHASE_C0 = 8'h48;
  localparam logic [7:0] ADDR_PHASE_C1 = 8'h49;
  localparam logic [7:0] ADDR_PHASE_D = 8'h58;
  // Register map B: power, bias, format, amplitude
  localparam logic [7:0] ADDR_STATE_A0 = 8'h2C;
  localparam logic [7:0] ADDR_STATE_A1 = 8'h2D;
  localparam logic [7:0] ADDR_STATE_A2 = 8'h2E;
  localparam logic [7:0] ADDR_STATE_B0 = 8'h3C;
  localparam logic [7:0] ADDR_STATE_B1 = 8'h3D;
  localparam logic [7:0] ADDR_STATE_C0 = 8'h4C;
  localparam logic [7:0] ADDR_STATE_C1 = 8'h4D;
  localparam logic [7:0] ADDR_STATE_D = 8'h5C;
  // Shared enable register and global bias type register
  localparam logic [7:0] ADDR_ENABLE = 8'h76;
  localparam logic [7:0] ADDR_BIAS_TYPE = 8'h19;
  localparam int BIAS_TYPE_BIT = 7;
  // Phase register field positions
  localparam int FINE_LO_POS = 5;
  localparam int SRC_POS = 4;
  localparam int COARSE_POS = 1;
  localparam int FINE_HI_POS = 0;
  // State register field positions
  localparam int PD_POS = 7;
  localparam int BIAS_POS = 5;
  localparam int STYLE_POS = 4;
  localparam int AMP_POS = 2;
  // Reset values
  localparam logic RST_SRC = 1'h1;
  localparam logic [2:0] RST_COARSE = 3'h0;
  localparam logic [2:0] RST_FINE = 3'h0;
  localparam logic RST_BIAS = 1'h0;
  localparam logic [1:0] RST_AMP = 2'h0;
  localparam logic RST_PD = 1'h0;
  localparam logic RST_STYLE = 1'h0;
  localparam logic RST_EN = 1'h0;
  localparam logic RST_BIAS_TYPE = 1'h0;
  // Coarse delay step in picoseconds
  localparam int COARSE_STEP_PS = 254;
  // Format codes
  typedef enum logic {
    SROCFG_FMT_LVDS = 1'b0,
    SROCFG_FMT_LVPECL = 1'b1
  } srocfg_fmt_e;
  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } srocfg_bus_s;
  // Per-output field set
  typedef struct packed {
    logic src_sysref;
    logic [2:0] coarse;
    logic [2:0] fine;
    logic bias;
    logic [1:0] amp;
    logic pd;
    logic style;
    logic en;
  } srocfg_fields_s;
  // Effective per-output drive controls
  typedef struct packed {
    logic powered;
    logic toggling;
    logic lvpecl;
    logic [1:0] amp;
    logic bias_active;
    logic src_sysref;
    logic [2:0] coarse;
    logic [2:0] fine;
  } srocfg_drive_s;
endpackage
`default_nettype wire

/* rtl/srocfg_channel.sv */
`default_nettype none
// Turns one output's stored fields into its effective drive controls
module srocfg_channel (
  input wire srocfg_pkg::srocfg_fields_s fields_in,
  input wire logic bias_type_in,
  output srocfg_pkg::srocfg_drive_s drive_out
);
  import srocfg_pkg::*;

  // Combinational decode of one output
  always_comb begin
    drive_out.src_sysref = fields_in.src_sysref;
    drive_out.coarse = fields_in.coarse;
    drive_out.fine = fields_in.fine;
    // Bias only with the global type bit set
    drive_out.bias_active = fields_in.bias & bias_type_in;
    drive_out.powered = ~fields_in.pd;
    if (fields_in.pd) begin
      // Powered down: format, enable and amplitude ignored
      drive_out.toggling = 1'b0;
      drive_out.lvpecl = SROCFG_FMT_LVDS;
      drive_out.amp = RST_AMP;
    end else begin
      drive_out.toggling = fields_in.en;
      drive_out.lvpecl = fields_in.style;
      drive_out.amp = fields_in.amp;
    end
  end
endmodule
`default_nettype wire

/* verification/srocfg_bank_props.sv */
`default_nettype none
// Watches the bank ports: field writes, readback and drive gating
module srocfg_bank_props #(
  parameter int NUM_OUTPUTS = 8
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire srocfg_pkg::srocfg_bus_s bus_in,
  input wire logic [7:0] rdata_out,
  input wire logic bias_type_out,
  input wire srocfg_pkg::srocfg_drive_s [NUM_OUTPUTS-1:0] drive_out,
  input wire logic [NUM_OUTPUTS-1:0] clock_gate_out
);
  import srocfg_pkg::*;
  // Write decodes of interest
  wire logic wr_a0 = bus_in.wr && bus_in.addr == ADDR_PHASE_A0;
  wire logic wr_d = bus_in.wr && bus_in.addr == ADDR_STATE_D && !bus_in.wdata[7];
  wire logic wr_bt = bus_in.wr && bus_in.addr == ADDR_BIAS_TYPE;
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  property p_pd;
    !drive_out[0].powered |-> !clock_gate_out[0] && !drive_out[0].lvpecl && drive_out[0].amp == 2'h0;
  endproperty
  a_pd: assert property (p_pd) else $error("powered down output still active");
  property p_en;
    bus_in.wr && bus_in.addr == ADDR_ENABLE |=>
      clock_gate_out[0] == ($past(bus_in.wdata[7]) && drive_out[0].powered);
  endproperty
  a_en: assert property (p_en) else $error("enable write not applied");
  property p_src; wr_a0 |=> drive_out[0].src_sysref == $past(bus_in.wdata[4]); endproperty
  a_src: assert property (p_src) else $error("source select wrong");
  property p_coarse; wr_a0 |=> drive_out[0].coarse == $past(bus_in.wdata[3:1]); endproperty
  a_coarse: assert property (p_coarse) else $error("coarse delay wrong");
  property p_fine; wr_a0 |=> drive_out[0].fine == {$past(bus_in.wdata[0]), $past(bus_in.wdata[6:5])}; endproperty
  a_fine: assert property (p_fine) else $error("fine delay wrong");
  property p_bias; drive_out[7].bias_active |-> bias_type_out; endproperty
  a_bias: assert property (p_bias) else $error("bias active without bias type");
  property p_btype; wr_bt |=> bias_type_out == $past(bus_in.wdata[7]); endproperty
  a_btype: assert property (p_btype) else $error("bias type write wrong");
  property p_fmt;
    wr_d |=> drive_out[7].amp == $past(bus_in.wdata[3:2]) && drive_out[7].lvpecl == $past(bus_in.wdata[4]);
  endproperty
  a_fmt: assert property (p_fmt) else $error("amplitude or format wrong");
  property p_unmap; bus_in.rd && bus_in.addr == 8'h00 |=> rdata_out == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // Main scenarios reached
  c_en: cover property (bus_in.wr && bus_in.addr == ADDR_ENABLE);
  c_bias: cover property (drive_out[7].bias_active);
  c_rd2: cover property (bus_in.rd ##1 bus_in.rd);
endmodule
bind srocfg_bank srocfg_bank_props #(.NUM_OUTPUTS(NUM_OUTPUTS)) u_props (.clk_in(clk_in), .srst_in(srst_in),
  .bus_in(bus_in), .rdata_out(rdata_out), .bias_type_out(bias_type_out), .drive_out(drive_out),
  .clock_gate_out(clock_gate_out));
`default_nettype wire

/* verification/sysref_output_state_config_tb_top.sv */
`default_nettype none
module sysref_output_state_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import srocfg_pkg::*;
  logic clk_in = 0, srst_in = 1, rd_d = 0, pd;
  srocfg_bus_s bus = '0;
  logic [7:0] rdata_out, rdat;
  logic bias_type_out;
  srocfg_drive_s [NUM_OUT-1:0] drive_out;
  logic [NUM_OUT-1:0] clock_gate_out;
  // Expected read data queue and register shadow table
  logic [7:0] exp_q[$], addr_t[18], mask_t[18], model[18];
  int errors = 0, samples_checked = 0;
  srocfg_bank dut (.clk_in(clk_in), .srst_in(srst_in), .bus_in(bus), .rdata_out(rdata_out),
    .bias_type_out(bias_type_out), .drive_out(drive_out), .clock_gate_out(clock_gate_out));
  always #2 clk_in = ~clk_in;
  task automatic check(string name, logic [7:0] seen, logic [7:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, expv, seen);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One bus cycle; a read notes its expected data
  task automatic access(logic [7:0] a, logic [7:0] d, logic w);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    if (!w) exp_q.push_back(d);
  endtask
  // Read data watcher, one cycle behind the strobe
  always @(posedge clk_in) begin
    if (rd_d) check("rdata", rdata_out, exp_q.pop_front());
    rd_d <= bus.rd;
  end
  // Hang guard
  initial begin
    #5000;
    errors++;
    finish_test();
  end
  initial begin
    void'($urandom(72167));
    addr_t = '{ADDR_PHASE_A0, ADDR_PHASE_A1, ADDR_PHASE_A2, ADDR_PHASE_B0, ADDR_PHASE_B1, ADDR_PHASE_C0,
      ADDR_PHASE_C1, ADDR_PHASE_D, ADDR_STATE_A0, ADDR_STATE_A1, ADDR_STATE_A2, ADDR_STATE_B0,
      ADDR_STATE_B1, ADDR_STATE_C0, ADDR_STATE_C1, ADDR_STATE_D, ADDR_ENABLE, ADDR_BIAS_TYPE};
    for (int i = 0; i < 18; i++) begin
      mask_t[i] = (i < 8) ? 8'h7F : (i < 16) ? 8'hBC : (i == 16) ? 8'hFF : 8'h80;
      model[i] = (i < 8) ? 8'h10 : 8'h00;
    end
    repeat (2) @(posedge clk_in);
    srst_in <= 0;
    // Read all, write random values, then check the drive controls
    for (int r = 0; r < 5; r++) begin
      for (int i = 0; i < 18; i++) access(addr_t[i], model[i], 0);
      for (int i = 0; i < 18; i++) begin
        rdat = $urandom;
        // Bias only on LVDS outputs; every output is taken as AC-coupled
        if (i >= 8 && i < 16 && rdat[4]) rdat[5] = 1'b0;
        model[i] = rdat & mask_t[i];
        access(addr_t[i], rdat, 1);
      end
      access(8'h00, 8'hFF, 1);
      @(posedge clk_in);
      bus <= '0;
      @(posedge clk_in);
      for (int i = 0; i < 8; i++) begin
        pd = model[i+8][7];
        check("powered", drive_out[i].powered, !pd);
        check("gate", clock_gate_out[i], model[16][7-i] & !pd);
        check("amp", drive_out[i].amp, pd ? 2'h0 : model[i+8][3:2]);
        check("lvpecl", drive_out[i].lvpecl, model[i+8][4] & !pd);
        check("bias", drive_out[i].bias_active, model[i+8][5] & model[17][7]);
        check("src", drive_out[i].src_sysref, model[i][4]);
        check("delay", {drive_out[i].coarse, drive_out[i].fine},
          {model[i][3:1], model[i][0], model[i][6:5]});
      end
      access(8'h00, 8'h00, 0);
    end
    @(posedge clk_in);
    bus <= '0;
    repeat (3) @(posedge clk_in);
    finish_test();
  end
endmodule
`default_nettype wire
